// file: hdl/ubf_top.sv
// baud generator, frame format and loop routing of the serial transceiver
//
// Contract
// - ir_modulation_on high enables infrared pulse coding and decoding.
// - infrared pulse width per ir_pulse_width: 1/4, 1/32, 1/16, 3/16 bit.
// - without infrared, baud is clock over sixteen times full divisor.
// - with infrared, baud is clock over 32 times divisor bits 12:1.
// - divisor upper bits in high register 4:0, lower in low register.
// - high write goes to holding buffer, committed by the low write.
// - baud generator stays stopped until transmitter or receiver first enabled.
// - baud generator disabled while the effective divisor is zero.
// - loopback disconnects rx pin, receiver source chosen by rx_source_sel.
// - in loop, source 0 is internal tx output, 1 the tx pin.
// - halt_in_wait stops the block during cpu wait, else it runs.
// - frame is start, eight or nine data bits, one stop.
// - wakeup by idle line, or by received character msb set.
// - idle ones counted from after start bit or after stop bit.
// - parity on inserts parity in msb on transmit, checks on receive.
// - even parity sets bit for odd ones count; odd parity inverts.
// - baud and frame registers readable and writable at any time.
// - loop with source 1 is single wire through the tx pin.
// - tx pin idles high, released whenever transmitter is disabled.
// - halted transfer pauses on wait entry and resumes after it.
//
// Implementation choices: register access over Avalon-MM and the address map.
`include "ubf_map.svh"
`timescale 1ns/100ps
`default_nettype none
module ubf_top #(
    parameter int DIV_W = 13
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_cpu_wait,
    input wire logic i_rx_pin,
    input wire logic i_tx_pin,
    output logic o_tx_pin,
    output logic o_tx_oe
);
    if (DIV_W != 13) begin : g_chk
        $error("ubf_top: divisor logic serves 13 bits only");
    end

    ubf_pkg::ubf_baud_high_type high_reg;
    ubf_pkg::ubf_baud_high_type hold_reg;
    logic [7:0] low_reg;
    ubf_pkg::ubf_frame_ctl_type fc_reg;
    logic tx_on_reg;
    logic rx_on_reg;
    logic started_reg;
    logic [DIV_W-1:0] div;
    logic [DIV_W-1:0] div_eff;
    logic [DIV_W-1:0] cnt_reg;
    logic tick_reg;
    logic run;
    logic baud_run;
    logic first_half;

    // bus slave
    logic req;
    logic acc;
    logic [2:0] widx;
    logic wr_lane;
    logic [31:0] rd_mux;
    assign req = i_avs_read | i_avs_write;
    assign acc = req & ~o_avs_waitrequest;
    assign widx = i_avs_address[4:2];
    assign wr_lane = acc & i_avs_write & i_avs_byteenable[0];

    // one cycle of wait per access keeps readdata and waitrequest registered
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_avs_waitrequest <= 1'b1;
        end else begin
            o_avs_waitrequest <= ~(req & o_avs_waitrequest);
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_avs_readdata <= 32'h0;
        end else if (req & o_avs_waitrequest) begin
            o_avs_readdata <= i_avs_read ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            high_reg <= `UBF_RST_BAUD_HIGH;
            hold_reg <= `UBF_RST_BAUD_HIGH;
            low_reg <= `UBF_RST_BAUD_LOW;
            fc_reg <= `UBF_RST_FRAME;
            tx_on_reg <= 1'b0;
            rx_on_reg <= 1'b0;
        end else if (wr_lane) begin
            case (widx)
                `UBF_ADDR_BAUD_HIGH: hold_reg <= i_avs_writedata[7:0];
                `UBF_ADDR_BAUD_LOW: begin
                    low_reg <= i_avs_writedata[7:0];
                    high_reg <= hold_reg;
                end
                `UBF_ADDR_FRAME: fc_reg <= i_avs_writedata[7:0];
                `UBF_ADDR_ENABLE: begin
                    tx_on_reg <= i_avs_writedata[`UBF_BIT_TX_ON];
                    rx_on_reg <= i_avs_writedata[`UBF_BIT_RX_ON];
                end
                default: ;
            endcase
        end
    end

    // baud generator
    assign div = {high_reg.div_hi, low_reg};
    // infrared drops bit 0 and doubles the rest, which gives the divisor with bit 0 cleared
    assign div_eff = high_reg.ir_on ? {div[DIV_W-1:1], 1'b0} : div;
    assign run = ~(fc_reg.halt_in_wait & i_cpu_wait);
    assign baud_run = started_reg & (div_eff != 13'h0);
    // the low half of the count is one unbroken run inside a tick
    assign first_half = cnt_reg < {1'b0, div[DIV_W-1:1]};

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            started_reg <= 1'b0;
        end else if (tx_on_reg | rx_on_reg) begin
            started_reg <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_reg <= 13'h0;
            tick_reg <= 1'b0;
        end else if (!baud_run) begin
            cnt_reg <= 13'h0;
            tick_reg <= 1'b0;
        end else if (!run) begin
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= cnt_reg == 13'h0;
            cnt_reg <= (cnt_reg == 13'h0) ? div_eff - 13'h1 : cnt_reg - 13'h1;
        end
    end

    // transmitter
    ubf_pkg::ubf_tx_state_type tx_state_reg;
    logic [8:0] tx_data_reg;
    logic tx_pend_reg;
    logic [8:0] tx_sh_reg;
    logic [3:0] tx_sub_reg;
    logic [3:0] tx_idx_reg;
    logic [3:0] last_idx;
    logic step;
    logic tx_load;
    logic tx_bit;
    logic pulse_win;
    logic [8:0] tx_word;

    assign step = tick_reg & run;
    assign last_idx = fc_reg.nine_bits ? 4'h8 : 4'h7;
    assign tx_load = step & (tx_state_reg == ubf_pkg::TX_IDLE) & tx_pend_reg & tx_on_reg;

    always_comb begin
        tx_word = fc_reg.nine_bits ? tx_data_reg : {1'b0, tx_data_reg[7:0]};
        if (fc_reg.parity_on) begin
            if (fc_reg.nine_bits) begin
                tx_word[8] = ^tx_data_reg[7:0] ^ fc_reg.odd_parity_sel;
            end else begin
                tx_word[7] = ^tx_data_reg[6:0] ^ fc_reg.odd_parity_sel;
            end
        end
    end

    // a data write while a character is pending is dropped
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tx_data_reg <= 9'h0;
            tx_pend_reg <= 1'b0;
        end else if (wr_lane && widx == `UBF_ADDR_TX_DATA && !tx_pend_reg && tx_on_reg) begin
            tx_data_reg <= i_avs_writedata[8:0];
            tx_pend_reg <= 1'b1;
        end else if (tx_load || !tx_on_reg) begin
            tx_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tx_state_reg <= ubf_pkg::TX_IDLE;
            tx_sh_reg <= 9'h0;
            tx_sub_reg <= 4'h0;
            tx_idx_reg <= 4'h0;
        end else if (!tx_on_reg) begin
            tx_state_reg <= ubf_pkg::TX_IDLE;
            tx_sub_reg <= 4'h0;
        end else if (step) begin
            tx_sub_reg <= tx_sub_reg + 4'h1;
            case (tx_state_reg)
                ubf_pkg::TX_IDLE: begin
                    tx_sub_reg <= 4'h0;
                    if (tx_pend_reg) begin
                        tx_sh_reg <= tx_word;
                        tx_idx_reg <= 4'h0;
                        tx_state_reg <= ubf_pkg::TX_START;
                    end
                end
                ubf_pkg::TX_START: begin
                    if (tx_sub_reg == `UBF_TICK_LAST) begin
                        tx_state_reg <= ubf_pkg::TX_DATA;
                    end
                end
                ubf_pkg::TX_DATA: begin
                    if (tx_sub_reg == `UBF_TICK_LAST) begin
                        tx_sh_reg <= {1'b0, tx_sh_reg[8:1]};
                        tx_idx_reg <= tx_idx_reg + 4'h1;
                        if (tx_idx_reg == last_idx) begin
                            tx_state_reg <= ubf_pkg::TX_STOP;
                        end
                    end
                end
                ubf_pkg::TX_STOP: begin
                    if (tx_sub_reg == `UBF_TICK_LAST) begin
                        tx_state_reg <= ubf_pkg::TX_IDLE;
                    end
                end
                default: tx_state_reg <= ubf_pkg::TX_IDLE;
            endcase
        end
    end

    always_comb begin
        case (tx_state_reg)
            ubf_pkg::TX_START: tx_bit = 1'b0;
            ubf_pkg::TX_DATA: tx_bit = tx_sh_reg[0];
            default: tx_bit = 1'b1;
        endcase
        case (high_reg.pulse_width)
            2'b11: pulse_win = tx_sub_reg < `UBF_PW_QUARTER;
            2'b10: pulse_win = (tx_sub_reg == 4'h0) & first_half;
            2'b01: pulse_win = tx_sub_reg < `UBF_PW_SIXTEENTH;
            default: pulse_win = tx_sub_reg < `UBF_PW_3SIXTEENTH;
        endcase
    end

    // with infrared on, a zero bit becomes a short low pulse; the line stays high otherwise
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_tx_pin <= 1'b1;
            o_tx_oe <= 1'b0;
        end else begin
            o_tx_oe <= tx_on_reg;
            if (!tx_on_reg) begin
                o_tx_pin <= 1'b1;
            end else if (high_reg.ir_on) begin
                o_tx_pin <= tx_bit | ~pulse_win;
            end else begin
                o_tx_pin <= tx_bit;
            end
        end
    end

    // receiver
    ubf_pkg::ubf_rx_state_type rx_state_reg;
    logic rx_src_lvl;
    logic rx_val;
    logic low_seen_reg;
    logic smp;
    logic [8:0] rx_sh_reg;
    logic [3:0] rx_sub_reg;
    logic [3:0] rx_idx_reg;
    logic [8:0] rx_data_reg;
    logic full_reg;
    logic perr_reg;
    logic ferr_reg;
    logic idle_reg;
    logic wake_reg;
    logic [7:0] idle_cnt_reg;
    logic idle_armed_reg;
    logic [7:0] idle_target;
    logic rx_done;
    logic perr_now;
    logic msb_now;
    logic idle_hit;
    logic stat_clr;
    logic cnt_en;

    always_comb begin
        if (!fc_reg.loopback_sel) begin
            rx_src_lvl = i_rx_pin;
        end else if (fc_reg.rx_source_sel) begin
            rx_src_lvl = i_tx_pin;
        end else begin
            rx_src_lvl = o_tx_pin;
        end
    end

    // short pulses can fall between ticks, so low is caught on every clock
    assign rx_val = high_reg.ir_on ? ~(low_seen_reg | ~rx_src_lvl) : rx_src_lvl;
    assign smp = step & (((rx_state_reg == ubf_pkg::RX_START) && rx_sub_reg == `UBF_TICK_MID)
        || ((rx_state_reg == ubf_pkg::RX_DATA || rx_state_reg == ubf_pkg::RX_STOP)
        && rx_sub_reg == `UBF_TICK_LAST));
    assign rx_done = smp & (rx_state_reg == ubf_pkg::RX_STOP);
    assign perr_now = fc_reg.parity_on & (fc_reg.odd_parity_sel ^ (fc_reg.nine_bits ?
        ^rx_sh_reg : ^rx_sh_reg[7:0]));
    assign msb_now = fc_reg.nine_bits ? rx_sh_reg[8] : rx_sh_reg[7];
    assign idle_target = fc_reg.nine_bits ? `UBF_IDLE_TICKS_9 : `UBF_IDLE_TICKS_8;
    assign idle_hit = idle_armed_reg & (idle_cnt_reg == idle_target);
    assign stat_clr = acc & i_avs_read & (widx == `UBF_ADDR_RX_STAT);
    assign cnt_en = fc_reg.idle_count_start ? (rx_state_reg == ubf_pkg::RX_IDLE)
        : (rx_state_reg != ubf_pkg::RX_START);

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            low_seen_reg <= 1'b0;
        end else if (smp || !high_reg.ir_on) begin
            low_seen_reg <= 1'b0;
        end else if (run && !rx_src_lvl) begin
            low_seen_reg <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rx_state_reg <= ubf_pkg::RX_IDLE;
            rx_sh_reg <= 9'h0;
            rx_sub_reg <= 4'h0;
            rx_idx_reg <= 4'h0;
        end else if (!rx_on_reg) begin
            rx_state_reg <= ubf_pkg::RX_IDLE;
        end else if (step) begin
            rx_sub_reg <= rx_sub_reg + 4'h1;
            case (rx_state_reg)
                ubf_pkg::RX_IDLE: begin
                    rx_sub_reg <= 4'h0;
                    if (!rx_val) begin
                        rx_state_reg <= ubf_pkg::RX_START;
                    end
                end
                ubf_pkg::RX_START: begin
                    if (rx_sub_reg == `UBF_TICK_MID) begin
                        rx_sub_reg <= 4'h0;
                        rx_idx_reg <= 4'h0;
                        rx_sh_reg <= 9'h0;
                        rx_state_reg <= rx_val ? ubf_pkg::RX_IDLE : ubf_pkg::RX_DATA;
                    end
                end
                ubf_pkg::RX_DATA: begin
                    if (rx_sub_reg == `UBF_TICK_LAST) begin
                        rx_sh_reg[rx_idx_reg] <= rx_val;
                        rx_idx_reg <= rx_idx_reg + 4'h1;
                        if (rx_idx_reg == last_idx) begin
                            rx_state_reg <= ubf_pkg::RX_STOP;
                        end
                    end
                end
                ubf_pkg::RX_STOP: begin
                    if (rx_sub_reg == `UBF_TICK_LAST) begin
                        rx_state_reg <= ubf_pkg::RX_IDLE;
                    end
                end
                default: rx_state_reg <= ubf_pkg::RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            idle_cnt_reg <= 8'h0;
            idle_armed_reg <= 1'b0;
        end else if (!rx_on_reg) begin
            idle_cnt_reg <= 8'h0;
        end else if (step) begin
            if (rx_state_reg == ubf_pkg::RX_START) begin
                idle_armed_reg <= 1'b1;
            end else if (idle_hit) begin
                idle_armed_reg <= 1'b0;
            end
            if (!rx_val || !cnt_en) begin
                idle_cnt_reg <= 8'h0;
            end else if (idle_cnt_reg != idle_target) begin
                idle_cnt_reg <= idle_cnt_reg + 8'h1;
            end
        end
    end

    // hardware set wins over a read clear in the same cycle
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rx_data_reg <= 9'h0;
            full_reg <= 1'b0;
            perr_reg <= 1'b0;
            ferr_reg <= 1'b0;
            idle_reg <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            if (rx_done) begin
                rx_data_reg <= fc_reg.nine_bits ? rx_sh_reg : {1'b0, rx_sh_reg[7:0]};
            end
            full_reg <= rx_done | (full_reg & ~stat_clr);
            perr_reg <= (rx_done & perr_now) | (perr_reg & ~stat_clr);
            ferr_reg <= (rx_done & ~rx_val) | (ferr_reg & ~stat_clr);
            idle_reg <= (step & idle_hit) | (idle_reg & ~stat_clr);
            wake_reg <= (fc_reg.wake_mark ? (rx_done & msb_now) : (step & idle_hit))
                | (wake_reg & ~stat_clr);
        end
    end

    always_comb begin
        rd_mux = 32'h0;
        case (widx)
            `UBF_ADDR_BAUD_HIGH: rd_mux[7:0] = high_reg;
            `UBF_ADDR_BAUD_LOW: rd_mux[7:0] = low_reg;
            `UBF_ADDR_FRAME: rd_mux[7:0] = fc_reg;
            `UBF_ADDR_ENABLE: begin
                rd_mux[`UBF_BIT_TX_ON] = tx_on_reg;
                rd_mux[`UBF_BIT_RX_ON] = rx_on_reg;
            end
            `UBF_ADDR_TX_DATA: rd_mux[8:0] = tx_data_reg;
            `UBF_ADDR_RX_STAT: begin
                rd_mux[8:0] = rx_data_reg;
                rd_mux[`UBF_STAT_FULL] = full_reg;
                rd_mux[`UBF_STAT_PERR] = perr_reg;
                rd_mux[`UBF_STAT_FERR] = ferr_reg;
                rd_mux[`UBF_STAT_IDLE] = idle_reg;
                rd_mux[`UBF_STAT_WAKE] = wake_reg;
                rd_mux[`UBF_STAT_TXBUSY] = tx_pend_reg | (tx_state_reg != ubf_pkg::TX_IDLE);
                rd_mux[`UBF_STAT_BAUDRUN] = baud_run;
            end
            default: rd_mux = 32'h0;
        endcase
    end

    AST_DIV_ZERO_STOP:
    assert property (@(posedge i_clk) disable iff (i_sys_rst) (div_eff == 13'h0) |=> !tick_reg)
        else $error("tick with zero divisor");
    AST_NOT_STARTED:
    assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !started_reg |-> !tick_reg && cnt_reg == 13'h0) else $error("baud ran before enable");
    AST_HIGH_BUFFERED:
    assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (wr_lane && widx == `UBF_ADDR_BAUD_HIGH) |=> $stable(high_reg))
        else $error("high write took effect early");
    AST_LOW_COMMITS:
    assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (wr_lane && widx == `UBF_ADDR_BAUD_LOW) |=> high_reg == $past(hold_reg))
        else $error("low write did not commit high");
    AST_IR_HALF:
    assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (high_reg.ir_on && div[12:1] == 12'h1 && baud_run && run && tick_reg)
        |=> !tick_reg) else $error("infrared tick period wrong");
    AST_TX_RELEASE:
    assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !tx_on_reg |=> !o_tx_oe && o_tx_pin) else $error("tx pin driven while off");
    AST_TX_IDLE_HIGH:
    assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (tx_on_reg && tx_state_reg == ubf_pkg::TX_IDLE) |=> o_tx_pin && o_tx_oe)
        else $error("tx pin not idle high");
    AST_HALT_FREEZE:
    assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!run && tx_on_reg && rx_on_reg) |=> $stable(tx_state_reg) && $stable(rx_state_reg))
        else $error("state moved in halted wait");
    AST_TX_PARITY:
    assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (tx_load && fc_reg.parity_on && !fc_reg.nine_bits)
        |=> (^tx_sh_reg[7:0]) == $past(fc_reg.odd_parity_sel)) else $error("tx parity wrong");
    AST_RX_PERR:
    assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (rx_done && perr_now) |=> perr_reg) else $error("parity error not flagged");
endmodule : ubf_top
`default_nettype wire

// file: hdl/ubf_map.svh
// register offsets, reset values and timing counts of the serial config block
`ifndef UBF_MAP_SVH
`define UBF_MAP_SVH
`define UBF_ADDR_BAUD_HIGH 3'h0
`define UBF_ADDR_BAUD_LOW 3'h1
`define UBF_ADDR_FRAME 3'h2
`define UBF_ADDR_ENABLE 3'h3
`define UBF_ADDR_TX_DATA 3'h4
`define UBF_ADDR_RX_STAT 3'h5
`define UBF_RST_BAUD_HIGH 8'h00
`define UBF_RST_BAUD_LOW 8'h00
`define UBF_RST_FRAME 8'h00
`define UBF_BIT_TX_ON 0
`define UBF_BIT_RX_ON 1
`define UBF_STAT_FULL 16
`define UBF_STAT_PERR 17
`define UBF_STAT_FERR 18
`define UBF_STAT_IDLE 19
`define UBF_STAT_WAKE 20
`define UBF_STAT_TXBUSY 21
`define UBF_STAT_BAUDRUN 22
`define UBF_TICK_LAST 4'hf
`define UBF_TICK_MID 4'h7
`define UBF_PW_QUARTER 4'h4
`define UBF_PW_SIXTEENTH 4'h1
`define UBF_PW_3SIXTEENTH 4'h3
`define UBF_IDLE_TICKS_8 8'ha0
`define UBF_IDLE_TICKS_9 8'hb0
`endif

// file: hdl/ubf_pkg.sv
// types of the serial baud and frame configuration block
package ubf_pkg;
    typedef struct packed {
        logic ir_on;
        logic [1:0] pulse_width;
        logic [4:0] div_hi;
    } ubf_baud_high_type;
    typedef struct packed {
        logic loopback_sel;
        logic halt_in_wait;
        logic rx_source_sel;
        logic nine_bits;
        logic wake_mark;
        logic idle_count_start;
        logic parity_on;
        logic odd_parity_sel;
    } ubf_frame_ctl_type;
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} ubf_tx_state_type;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ubf_rx_state_type;
endpackage : ubf_pkg

// file: bench/ubf_partner.sv
// remote serial device: frame sender on the rx pin and the pulled-up tx wire
`timescale 1ns/100ps
`default_nettype none
module ubf_partner (
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [8:0] i_char,
    input wire logic i_nine,
    input wire logic [15:0] i_bit_clks,
    input wire logic i_tx_oe,
    input wire logic i_tx_val,
    output logic o_rx,
    output logic o_wire
);
    logic [10:0] frame;
    // released wire falls to its pull-up, never keeps the last level
    assign o_wire = i_tx_oe ? i_tx_val : 1'b1;
    initial begin
        o_rx = 1'b1;
        forever begin
            @(posedge i_clk);
            if (i_go) begin
                frame = i_nine ? {1'b1, i_char, 1'b0} : {2'b11, i_char[7:0], 1'b0};
                for (int i = 0; i < (i_nine ? 11 : 10); i++) begin
                    o_rx <= frame[i];
                    repeat (i_bit_clks) @(posedge i_clk);
                end
                o_rx <= 1'b1;
            end
        end
    end
endmodule : ubf_partner
`default_nettype wire

// file: bench/testbench.sv
// self-checking bench of the serial baud and frame configuration block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] addr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'h1;
    logic cpu_wait = 1'b0;
    logic go = 1'b0;
    logic [8:0] ch = 9'h000;
    logic [31:0] rdata;
    logic waitreq, tx_pin, tx_oe, rx_line, tx_wire;
    logic [63:0] q[$];
    logic [63:0] e;
    logic [7:0] fv;
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;
    int k;
    ubf_top dut_u (.i_clk(clk), .i_sys_rst(rst), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_cpu_wait(cpu_wait),
        .i_rx_pin(rx_line), .i_tx_pin(tx_wire), .o_tx_pin(tx_pin), .o_tx_oe(tx_oe));
    ubf_partner far_u (.i_clk(clk), .i_go(go), .i_char(ch), .i_nine(1'b0),
        .i_bit_clks(16'h0010), .i_tx_oe(tx_oe), .i_tx_val(tx_pin), .o_rx(rx_line),
        .o_wire(tx_wire));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic finish_test();
        $display("mismatches %0d compares %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic check(input string what, input logic [31:0] x, input logic [31:0] y);
        compares++;
        if (y !== x) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, x, y);
        end
    endtask : check
    // request held until waitrequest is sampled low or 50 edges pass, released after that edge
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
        input logic [31:0] m);
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        if (!w) begin
            q.push_back({m, d});
        end
        for (int i = 0; i < 50; i++) begin
            @(posedge clk);
            if (waitreq === 1'b0) break;
        end
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic tx_frame(input logic [8:0] c, input int nb, input int bc);
        for (k = 0; k < 5000 && tx_pin !== 1'b0; k++) @(posedge clk);
        repeat (bc / 2) @(posedge clk);
        check("start", 32'h0, {31'h0, tx_pin});
        for (int i = 0; i < nb; i++) begin
            repeat (bc) @(posedge clk);
            check("data", {31'h0, c[i]}, {31'h0, tx_pin});
        end
        repeat (bc) @(posedge clk);
        check("stop", 32'h1, {31'h0, tx_pin});
    endtask : tx_frame
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (rd && waitreq === 1'b0 && q.size() > 0) begin
            e = q.pop_front();
            check("rdata", e[31:0] & e[63:32], rdata & e[63:32]);
        end
        if (cycles == 20000) begin
            bad_count++;
            finish_test();
        end
    end
    initial begin
        static logic [7:0] hi_t[4] = '{8'h00, 8'h80, 8'h80, 8'h00};
        static logic [7:0] lo_t[4] = '{8'h00, 8'h01, 8'h02, 8'h01};
        static logic [7:0] fr_t[3] = '{8'h02, 8'h03, 8'h12};
        static logic [8:0] px_t[3] = '{9'h087, 9'h007, 9'h101};
        static int w_t[4] = '{12, 4, 2, 16};
        void'($urandom(37828));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) bus(0, 5'(i * 4 + (i / 3) * 12), 0, '1);
        bus(1, 5'h04, 32'h01, 0);
        bus(0, 5'h14, 0, 32'h0040_0000);
        check("oe off", 0, {31'h0, tx_oe});
        bus(1, 5'h0c, 32'h1, 0);
        bus(0, 5'h14, 32'h0040_0000, 32'h0040_0000);
        check("oe on", 1, {31'h0, tx_oe});
        bus(1, 5'h00, 32'h1f, 0);
        bus(0, 5'h00, 0, '1);
        bus(1, 5'h04, 32'h00, 0);
        bus(0, 5'h00, 32'h1f, '1);
        for (int i = 0; i < 4; i++) begin
            bus(1, 5'h00, hi_t[i], 0);
            bus(1, 5'h04, lo_t[i], 0);
            bus(0, 5'h14, {9'h0, i > 1, 22'h0}, 32'h0040_0000);
        end
        fv = 8'($urandom);
        bus(1, 5'h08, fv, 0);
        bus(0, 5'h08, fv, '1);
        be <= 4'h0;
        bus(1, 5'h08, 32'h0, 0);
        be <= 4'h1;
        bus(0, 5'h08, fv, '1);
        bus(1, 5'h08, 32'h0, 0);
        bus(1, 5'h0c, 32'h3, 0);
        ch = 9'($urandom & 32'hff);
        bus(1, 5'h10, ch, 0);
        tx_frame(ch, 8, 16);
        bus(1, 5'h04, 32'h02, 0);
        bus(1, 5'h10, 32'h96, 0);
        tx_frame(9'h096, 8, 32);
        bus(1, 5'h04, 32'h01, 0);
        for (int i = 0; i < 3; i++) begin
            bus(1, 5'h08, fr_t[i], 0);
            bus(1, 5'h10, i == 2 ? 32'h001 : 32'h007, 0);
            tx_frame(px_t[i], 8 + i / 2, 16);
        end
        bus(1, 5'h08, 32'h40, 0);
        cpu_wait <= 1'b1;
        bus(1, 5'h10, 32'h55, 0);
        repeat (100) @(posedge clk);
        check("halted", 1, {31'h0, tx_pin});
        cpu_wait <= 1'b0;
        tx_frame(9'h055, 8, 16);
        bus(1, 5'h08, 32'h00, 0);
        cpu_wait <= 1'b1;
        bus(1, 5'h10, 32'h33, 0);
        tx_frame(9'h033, 8, 16);
        cpu_wait <= 1'b0;
        bus(0, 5'h14, 32'h0040_0000, 32'h0047_0000);
        bus(1, 5'h08, 32'h02, 0);
        // even parity checked, the sent bit 7 breaks it on purpose
        fv = 8'($urandom);
        ch <= {1'b0, ~^fv[6:0], fv[6:0]};
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (200) @(posedge clk);
        bus(0, 5'h14, {14'h0, 2'b11, 8'h0, ch[7:0]}, 32'h0003_00ff);
        // both ends enabled before looping, the loop needs them together
        bus(1, 5'h0c, 32'h3, 0);
        for (int j = 0; j < 2; j++) begin
            bus(1, 5'h08, j ? 32'ha0 : 32'h88, 0);
            bus(1, 5'h10, 32'hdc - j, 0);
            repeat (200) @(posedge clk);
            bus(0, 5'h14, 32'h0011_00dc - j * 32'h0010_0001, 32'h0011_00ff);
        end
        bus(1, 5'h08, 32'h00, 0);
        for (int c = 0; c < 4; c++) begin
            bus(1, 5'h00, {24'h0, 1'b1, 2'(c), 5'h0}, 0);
            bus(1, 5'h04, 32'h04, 0);
            bus(1, 5'h10, 32'h0, 0);
            for (k = 0; k < 5000 && tx_pin !== 1'b0; k++) @(posedge clk);
            for (k = 0; k < 100 && tx_pin === 1'b0; k++) @(posedge clk);
            check("ir pulse", w_t[c], k);
            repeat (700) @(posedge clk);
        end
        bus(0, 5'h14, 32'h0018_0000, 32'h0018_0000);
        repeat (2) @(posedge clk);
        finish_test();
    end
endmodule : testbench
`default_nettype wire
